/* File: hw/svtm_top.sv */
// Register top of the supply throttle monitor with its instances
// Assumes one AHB-Lite master, single word transfers, one clock
//
// Decided for this implementation: register access over AHB-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module svtm_top (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave port
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Converter samples, one ten-bit field per instance
  input wire logic [svtm_pkg::SVTM_NUM_INST*svtm_pkg::SVTM_ADC_W-1:0]
    supply_sense_inputs,
  // Throttle sources
  input wire logic override_input_pin_n,
  input wire logic pwm_force_n,
  input wire logic duty_limit_flag,
  // Open-drain throttle pin and combined level
  input wire logic throttle_pin_in,
  output logic throttle_pin_out,
  output logic throttle_pin_oe,
  output logic throttle_n,
  // Interrupt
  output logic guard_interrupt
);
  import svtm_pkg::*;
  localparam int NI = SVTM_NUM_INST;

  logic [7:0] ctrl_reg [NI];
  logic [7:0] test_reg [NI];
  logic [15:0] thresh_reg [NI];
  logic [15:0] lpf1_reg [NI];
  logic [15:0] lpf2_reg [NI];
  logic [15:0] delay_reg [NI];
  logic [SVTM_INT_W-1:0] int_status_reg;
  logic [SVTM_INT_W-1:0] int_enable_reg;
  logic [SVTM_INT_W-1:0] int_set;
  logic [SVTM_INT_W-1:0] int_clr;
  svtm_alt_t alt_reg;
  logic pin_mon_reg;
  logic accept;
  logic wr_pend_reg;
  logic rd_pend_reg;
  logic [7:0] addr_reg;
  logic hreadyout_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] rd_val;
  logic [NI-1:0] cmp_hi_v;
  logic [NI-1:0] cmp_lo_v;
  logic [NI-1:0] thr_v;
  logic [7:0] mon_v [NI];
  logic [NI-1:0] cmp_hi_d_reg;
  logic [NI-1:0] cmp_lo_d_reg;
  logic force_d_reg;
  logic throttle_act;
  logic throttle_n_reg;
  logic pin_oe_reg;
  logic irq_reg;

  // Address falls in the slot of instance i
  function automatic logic in_inst(input logic [7:0] a, input int i);
    return (a[7:6] == 2'b00) && (a[SVTM_INST_BIT] == i[0]);
  endfunction

  // Monitor instances, each tied to its own sample channel
  for (genvar i = 0; i < NI; i++) begin : g_inst
    svtm_inst_if lk ();
    assign lk.disable_inst = ctrl_reg[i][SVTM_CTRL_DIS];
    assign lk.test_sel = ctrl_reg[i][SVTM_CTRL_TSEL];
    assign lk.dsel = svtm_dsel_t'(ctrl_reg[i][SVTM_CTRL_DSEL +: 2]);
    assign lk.lpf_w4 = ctrl_reg[i][SVTM_CTRL_W4 +: 2];
    assign lk.lpf_rate[0] = lpf1_reg[i];
    assign lk.lpf_rate[1] = lpf2_reg[i];
    assign lk.lo_ref = thresh_reg[i][7:0];
    assign lk.hi_ref = thresh_reg[i][15:8];
    assign lk.test_data = test_reg[i];
    assign lk.delay = delay_reg[i];
    assign lk.sample =
      supply_sense_inputs[i*SVTM_ADC_W +: SVTM_ADC_W];
    assign cmp_hi_v[i] = lk.cmp_hi;
    assign cmp_lo_v[i] = lk.cmp_lo;
    assign thr_v[i] = lk.thr;
    assign mon_v[i] = lk.mon_data;
    svtm_inst u_inst (
      .hclk(hclk),
      .hresetn(hresetn),
      .lk(lk)
    );
  end

  // Bus front end; reads take one wait state so data leaves a flop
  assign accept = hsel && htrans[1] && hready;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      hreadyout_reg <= 1'b1;
      hrdata_reg <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= accept && hwrite;
      rd_pend_reg <= accept && !hwrite;
      hreadyout_reg <= !(accept && !hwrite);
      if (accept) begin
        addr_reg <= haddr[7:0];
      end
      if (rd_pend_reg) begin
        hrdata_reg <= rd_val;
      end
    end
  end

  // Per-instance configuration writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < NI; i++) begin
        ctrl_reg[i] <= SVTM_CTRL_RST;
        test_reg[i] <= SVTM_TEST_RST;
        thresh_reg[i] <= SVTM_THRESH_RST;
        lpf1_reg[i] <= SVTM_LPF_RST;
        lpf2_reg[i] <= SVTM_LPF_RST;
        delay_reg[i] <= SVTM_DELAY_RST;
      end
    end else if (wr_pend_reg) begin
      for (int i = 0; i < NI; i++) begin
        if (in_inst(addr_reg, i)) begin
          case (addr_reg[4:0])
            SVTM_OFF_CTRL: ctrl_reg[i] <= hwdata[7:0];
            SVTM_OFF_TEST: test_reg[i] <= hwdata[7:0];
            SVTM_OFF_THRESH: thresh_reg[i] <= hwdata[15:0];
            SVTM_OFF_LPF1: lpf1_reg[i] <= hwdata[15:0];
            SVTM_OFF_LPF2: lpf2_reg[i] <= hwdata[15:0];
            SVTM_OFF_DELAY: delay_reg[i] <= hwdata[15:0];
            default: ;
          endcase
        end
      end
    end
  end

  // Shared configuration writes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_enable_reg <= '0;
      alt_reg <= SVTM_ALT_GPIO;
    end else if (wr_pend_reg) begin
      if (addr_reg == SVTM_OFF_INT_ENABLE) begin
        int_enable_reg <= hwdata[SVTM_INT_W-1:0];
      end
      if (addr_reg == SVTM_OFF_PIN_CFG) begin
        alt_reg <= svtm_alt_t'(hwdata[1:0]);
      end
    end
  end

  // Event edges from force input and each comparator
  always_comb begin
    int_set = '0;
    int_set[SVTM_INT_FORCE] = !pwm_force_n && !force_d_reg;
    for (int i = 0; i < NI; i++) begin
      int_set[1 + 4*i + SVTM_INT_LO_RISE] =
        cmp_lo_v[i] && !cmp_lo_d_reg[i];
      int_set[1 + 4*i + SVTM_INT_HI_RISE] =
        cmp_hi_v[i] && !cmp_hi_d_reg[i];
      int_set[1 + 4*i + SVTM_INT_LO_FALL] =
        !cmp_lo_v[i] && cmp_lo_d_reg[i];
      int_set[1 + 4*i + SVTM_INT_HI_FALL] =
        !cmp_hi_v[i] && cmp_hi_d_reg[i];
    end
  end
  assign int_clr = (wr_pend_reg && addr_reg == SVTM_OFF_INT_STATUS) ?
                   hwdata[SVTM_INT_W-1:0] : '0;

  // Sticky status, write one to clear; a new event beats the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      int_status_reg <= '0;
      force_d_reg <= 1'b0;
      cmp_hi_d_reg <= '0;
      cmp_lo_d_reg <= '0;
    end else begin
      int_status_reg <= (int_status_reg & ~int_clr) | int_set;
      force_d_reg <= !pwm_force_n;
      cmp_hi_d_reg <= cmp_hi_v;
      cmp_lo_d_reg <= cmp_lo_v;
    end
  end

  // Interrupt line
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(int_status_reg & int_enable_reg);
    end
  end

  // All throttle sources merged; override needs no register setup at throttle_n, the pin is driven only in the two-way option
  assign throttle_act = !override_input_pin_n
                      || !pwm_force_n
                      || duty_limit_flag
                      || (|thr_v);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      throttle_n_reg <= 1'b1;
      pin_oe_reg <= 1'b0;
    end else begin
      throttle_n_reg <= !throttle_act;
      pin_oe_reg <= throttle_act && (alt_reg == SVTM_ALT_IO);
    end
  end

  // Pin level is tracked only when the pin belongs to this block
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_mon_reg <= 1'b1;
    end else if (alt_reg == SVTM_ALT_IN || alt_reg == SVTM_ALT_IO) begin
      pin_mon_reg <= throttle_pin_in;
    end
  end

  // Read mux on the latched address; unmapped words read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    for (int i = 0; i < NI; i++) begin
      if (in_inst(addr_reg, i)) begin
        case (addr_reg[4:0])
          SVTM_OFF_CTRL: rd_val = {24'h000000, ctrl_reg[i]};
          SVTM_OFF_TEST: rd_val = {14'h0000, cmp_lo_v[i], cmp_hi_v[i],
                                   mon_v[i], test_reg[i]};
          SVTM_OFF_THRESH: rd_val = {16'h0000, thresh_reg[i]};
          SVTM_OFF_LPF1: rd_val = {16'h0000, lpf1_reg[i]};
          SVTM_OFF_LPF2: rd_val = {16'h0000, lpf2_reg[i]};
          SVTM_OFF_DELAY: rd_val = {16'h0000, delay_reg[i]};
          default: ;
        endcase
      end
    end
    if (addr_reg == SVTM_OFF_INT_STATUS) begin
      rd_val[SVTM_INT_W-1:0] = int_status_reg;
    end
    if (addr_reg == SVTM_OFF_INT_ENABLE) begin
      rd_val[SVTM_INT_W-1:0] = int_enable_reg;
    end
    if (addr_reg == SVTM_OFF_PIN_CFG) begin
      rd_val = {28'h0000000, throttle_n_reg, pin_mon_reg, alt_reg};
    end
  end

  // Outputs from flops, hresp tied low; open-drain data equals the level
  assign hreadyout = hreadyout_reg;
  assign hrdata = hrdata_reg;
  assign hresp = 1'b0;
  assign throttle_n = throttle_n_reg;
  assign throttle_pin_out = throttle_n_reg;
  assign throttle_pin_oe = pin_oe_reg;
  assign guard_interrupt = irq_reg;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_override;
    !override_input_pin_n |=> !throttle_n;
  endproperty
  a_override: assert property (p_override)
    else $error("override low did not throttle");
  property p_force;
    !pwm_force_n |=> !throttle_n;
  endproperty
  a_force: assert property (p_force)
    else $error("force input did not throttle");
  property p_duty;
    duty_limit_flag |=> !throttle_n;
  endproperty
  a_duty: assert property (p_duty)
    else $error("duty flag did not throttle");
  property p_irq;
    guard_interrupt == $past(|(int_status_reg & int_enable_reg));
  endproperty
  a_irq: assert property (p_irq)
    else $error("interrupt does not follow enabled status");
  property p_or;
    (|thr_v) |=> !throttle_n;
  endproperty
  a_or: assert property (p_or)
    else $error("instance throttle lost in merge");
  property p_idle;
    (override_input_pin_n && pwm_force_n && !duty_limit_flag &&
     thr_v == '0) |=> throttle_n;
  endproperty
  a_idle: assert property (p_idle)
    else $error("throttle with no source active");
  property p_oe;
    alt_reg != SVTM_ALT_IO |=> !throttle_pin_oe;
  endproperty
  a_oe: assert property (p_oe)
    else $error("pin driven outside two-way option");
  property p_drive;
    throttle_pin_oe == (!throttle_n && $past(alt_reg) == SVTM_ALT_IO);
  endproperty
  a_drive: assert property (p_drive)
    else $error("pin drive does not match throttle");
  property p_force_evt;
    $fell(pwm_force_n) |-> ##1 int_status_reg[SVTM_INT_FORCE] [*2];
  endproperty
  a_force_evt: assert property (p_force_evt)
    else $error("force event not latched");
  property p_edge_evt;
    $rose(cmp_hi_v[0]) |=> int_status_reg[1 + SVTM_INT_HI_RISE];
  endproperty
  a_edge_evt: assert property (p_edge_evt)
    else $error("comparator rise not latched");

  c_override: cover property (!override_input_pin_n ##1 !throttle_n);
  c_force_irq: cover property ($fell(pwm_force_n) ##[1:4] guard_interrupt);
  c_inst_thr: cover property ($rose(thr_v[1]) ##1 !throttle_n);
  c_read: cover property (rd_pend_reg ##1 hreadyout);
endmodule
`default_nettype wire

/* File: shared/svtm_pkg.sv */
// Constants, types and helpers for the supply throttle monitor
// Assumes one clock domain and 32-bit AHB-Lite register access
package svtm_pkg;
  // Structure
  localparam int SVTM_NUM_INST = 2;
  localparam int SVTM_CLK_MHZ = 200;
  localparam int SVTM_ADC_W = 10;
  localparam int SVTM_SMP_W = 8;
  localparam int SVTM_FRAC = 6;
  localparam int SVTM_ACC_W = SVTM_SMP_W + SVTM_FRAC;
  localparam int SVTM_SHIFT_W4 = 2;
  localparam int SVTM_SHIFT_W64 = 6;
  // Per-instance register offsets inside a 32-byte slot
  localparam logic [4:0] SVTM_OFF_CTRL = 5'h00;
  localparam logic [4:0] SVTM_OFF_TEST = 5'h04;
  localparam logic [4:0] SVTM_OFF_THRESH = 5'h08;
  localparam logic [4:0] SVTM_OFF_LPF1 = 5'h0c;
  localparam logic [4:0] SVTM_OFF_LPF2 = 5'h10;
  localparam logic [4:0] SVTM_OFF_DELAY = 5'h14;
  localparam int SVTM_INST_BIT = 5;
  // Shared register offsets
  localparam logic [7:0] SVTM_OFF_INT_STATUS = 8'h40;
  localparam logic [7:0] SVTM_OFF_INT_ENABLE = 8'h44;
  localparam logic [7:0] SVTM_OFF_PIN_CFG = 8'h48;
  // Control field positions
  localparam int SVTM_CTRL_DIS = 0;
  localparam int SVTM_CTRL_TSEL = 1;
  localparam int SVTM_CTRL_DSEL = 2;
  localparam int SVTM_CTRL_W4 = 4;
  // Reset values
  localparam logic [7:0] SVTM_CTRL_RST = 8'h00;
  localparam logic [7:0] SVTM_TEST_RST = 8'h00;
  localparam logic [15:0] SVTM_THRESH_RST = 16'hff00;
  localparam logic [15:0] SVTM_LPF_RST = 16'h0000;
  localparam logic [15:0] SVTM_DELAY_RST = 16'h0000;
  // Interrupt status layout: force bit, then four per instance
  localparam int SVTM_INT_W = 1 + 4 * SVTM_NUM_INST;
  localparam int SVTM_INT_FORCE = 0;
  localparam int SVTM_INT_LO_RISE = 0;
  localparam int SVTM_INT_HI_RISE = 1;
  localparam int SVTM_INT_LO_FALL = 2;
  localparam int SVTM_INT_HI_FALL = 3;
  // Pin function and data source selections
  typedef enum logic [1:0] {
    SVTM_ALT_GPIO = 2'b00,
    SVTM_ALT_IN = 2'b01,
    SVTM_ALT_IO = 2'b10,
    SVTM_ALT_RSVD = 2'b11
  } svtm_alt_t;
  typedef enum logic [1:0] {
    SVTM_DSEL_RAW = 2'b00,
    SVTM_DSEL_LPF1 = 2'b01,
    SVTM_DSEL_LPF2 = 2'b10,
    SVTM_DSEL_RSVD = 2'b11
  } svtm_dsel_t;

  // Running average on the full 8.6 accumulator
  function automatic logic [SVTM_ACC_W-1:0] svtm_lpf_step(
    input logic [SVTM_ACC_W-1:0] acc,
    input logic [SVTM_SMP_W-1:0] smp,
    input logic w4);
    logic [SVTM_ACC_W-1:0] full;
    full = {smp, {SVTM_FRAC{1'b0}}};
    if (w4) begin
      return acc - (acc >> SVTM_SHIFT_W4) + (full >> SVTM_SHIFT_W4);
    end
    return acc - (acc >> SVTM_SHIFT_W64) + (full >> SVTM_SHIFT_W64);
  endfunction
endpackage

/* File: shared/svtm_inst_if.sv */
// Link between the register top and one monitor instance
// Assumes both ends share hclk; carries no clock of its own
`timescale 1ns/1ps
`default_nettype none
interface svtm_inst_if;
  import svtm_pkg::*;
  logic disable_inst;
  logic test_sel;
  svtm_dsel_t dsel;
  logic [1:0] lpf_w4;
  logic [15:0] lpf_rate [2];
  logic [7:0] lo_ref;
  logic [7:0] hi_ref;
  logic [7:0] test_data;
  logic [15:0] delay;
  logic [SVTM_ADC_W-1:0] sample;
  logic [SVTM_SMP_W-1:0] mon_data;
  logic cmp_hi;
  logic cmp_lo;
  logic thr;
  modport top (output disable_inst, test_sel, dsel, lpf_w4, lpf_rate,
               lo_ref, hi_ref, test_data, delay, sample,
               input mon_data, cmp_hi, cmp_lo, thr);
  modport inst (input disable_inst, test_sel, dsel, lpf_w4, lpf_rate,
                lo_ref, hi_ref, test_data, delay, sample,
                output mon_data, cmp_hi, cmp_lo, thr);
endinterface
`default_nettype wire

/* File: hw/svtm_inst.sv */
// One supply monitor: input select, two filters, mux, compare, delay
// Assumes configuration is held steady by the register top
`timescale 1ns/1ps
`default_nettype none
module svtm_inst (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Configuration and status link
  svtm_inst_if.inst lk
);
  import svtm_pkg::*;

  logic [SVTM_SMP_W-1:0] front;
  logic [SVTM_SMP_W-1:0] fin [2];
  logic [SVTM_ACC_W-1:0] acc_reg [2];
  logic [15:0] div_reg [2];
  logic [SVTM_SMP_W-1:0] sel_data;
  logic [SVTM_SMP_W-1:0] data_reg;
  logic [1:0] cmp_reg;
  logic [15:0] tmr_reg [2];
  logic [1:0] del;
  logic thr_reg;

  // Test data or the top eight converter bits
  assign front = lk.test_sel ? lk.test_data :
                 lk.sample[SVTM_ADC_W-1 -: SVTM_SMP_W];
  assign fin[0] = front;
  assign fin[1] = acc_reg[0][SVTM_ACC_W-1 -: SVTM_SMP_W];

  // Cascaded first-order stages, each on its own rate divider
  for (genvar f = 0; f < 2; f++) begin : g_lpf
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        div_reg[f] <= 16'h0000;
        acc_reg[f] <= '0;
      end else if (lk.disable_inst) begin
        div_reg[f] <= 16'h0000;
        acc_reg[f] <= '0;
      end else if (div_reg[f] >= lk.lpf_rate[f]) begin
        div_reg[f] <= 16'h0000;
        acc_reg[f] <= svtm_lpf_step(acc_reg[f], fin[f],
                                    lk.lpf_w4[f]);
      end else begin
        div_reg[f] <= div_reg[f] + 16'h0001;
      end
    end
  end

  // Source for the comparators; reserved code falls to the last stage
  always_comb begin
    unique case (lk.dsel)
      SVTM_DSEL_RAW: sel_data = front;
      SVTM_DSEL_LPF1: sel_data = fin[1];
      default: sel_data = acc_reg[1][SVTM_ACC_W-1 -: SVTM_SMP_W];
    endcase
  end

  // Registered comparators against both references
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      data_reg <= 8'h00;
      cmp_reg <= 2'b00;
    end else if (lk.disable_inst) begin
      data_reg <= 8'h00;
      cmp_reg <= 2'b00;
    end else begin
      data_reg <= sel_data;
      cmp_reg[1] <= (sel_data >= lk.hi_ref);
      cmp_reg[0] <= (sel_data <= lk.lo_ref);
    end
  end

  // Qualification timers; release is immediate so recovery is fast
  for (genvar c = 0; c < 2; c++) begin : g_tmr
    always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
        tmr_reg[c] <= 16'h0000;
      end else if (!cmp_reg[c] || lk.disable_inst) begin
        tmr_reg[c] <= 16'h0000;
      end else if (tmr_reg[c] < lk.delay) begin
        tmr_reg[c] <= tmr_reg[c] + 16'h0001;
      end
    end
    assign del[c] = cmp_reg[c] && (tmr_reg[c] >= lk.delay);
  end

  // Instance throttle contribution
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      thr_reg <= 1'b0;
    end else begin
      thr_reg <= !lk.disable_inst && (|del);
    end
  end

  assign lk.mon_data = data_reg;
  assign lk.cmp_hi = cmp_reg[1];
  assign lk.cmp_lo = cmp_reg[0];
  assign lk.thr = thr_reg;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  property p_hi_cmp;
    cmp_reg[1] |-> (data_reg >= $past(lk.hi_ref));
  endproperty
  a_hi_cmp: assert property (p_hi_cmp)
    else $error("high compare set below reference");
  property p_lo_cmp;
    cmp_reg[0] |-> (data_reg <= $past(lk.lo_ref));
  endproperty
  a_lo_cmp: assert property (p_lo_cmp)
    else $error("low compare set above reference");
  property p_delay;
    $rose(thr_reg) |-> $past(cmp_reg != 2'b00, 1);
  endproperty
  a_delay: assert property (p_delay)
    else $error("throttle without a comparator");
  property p_disable;
    lk.disable_inst |=> (!thr_reg && cmp_reg == 2'b00);
  endproperty
  a_disable: assert property (p_disable)
    else $error("disabled instance still active");
  property p_front;
    (!lk.disable_inst && lk.dsel == SVTM_DSEL_RAW) |=>
      data_reg == $past(lk.test_sel ? lk.test_data :
                        lk.sample[SVTM_ADC_W-1 -: SVTM_SMP_W]);
  endproperty
  a_front: assert property (p_front)
    else $error("raw path does not carry front data");
endmodule
`default_nettype wire

/* File: tb/svtm_host_model.sv */
// Host side of the throttle pin: open-drain line with pull-up
// Assumes the device pulls low only while its enable is high
`timescale 1ns/1ps
`default_nettype none
module svtm_host_model (
  // Device pin drive
  input wire logic pin_out,
  input wire logic pin_oe,
  // Line level and host view
  output logic pin_level,
  output logic throttled
);
  // Pull-up wins whenever the device lets go of the line
  assign pin_level = (pin_oe && !pin_out) ? 1'b0 : 1'b1;
  assign throttled = !pin_level;
endmodule
`default_nettype wire

/* File: tb/svtm_top_tb.sv */
// Self-checking bench for the supply throttle monitor top
// Assumes one AHB-Lite master, hready fed back from hreadyout
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
  err_total++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module svtm_top_tb;
  import svtm_pkg::*;
  typedef struct {logic [7:0] a, td, lo, hi; logic [1:0] e;} svtm_row_t;
  // Base, test data, low ref, high ref, expected {high, low}
  svtm_row_t rows [5] = '{'{8'h00, 8'h80, 8'h40, 8'h80, 2'b10},
    '{8'h00, 8'h7f, 8'h40, 8'h80, 2'b00},
    '{8'h00, 8'h40, 8'h40, 8'h80, 2'b01},
    '{8'h00, 8'h41, 8'h40, 8'h80, 2'b00},
    '{8'h20, 8'hff, 8'h00, 8'hff, 2'b10}};
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, rdy_s;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, q, rd_s;
  logic [19:0] sense;
  logic ovr_n, pwm_n, duty, pin, out, oe, thr_n, irq, host_thr;
  logic [3:0] s;
  int err_total, checks_done;

  svtm_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .supply_sense_inputs(sense),
    .override_input_pin_n(ovr_n), .pwm_force_n(pwm_n),
    .duty_limit_flag(duty), .throttle_pin_in(pin),
    .throttle_pin_out(out), .throttle_pin_oe(oe), .throttle_n(thr_n),
    .guard_interrupt(irq));
  svtm_host_model host (.pin_out(out), .pin_oe(oe), .pin_level(pin),
    .throttled(host_thr));

  // 200 MHz clock
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // Sample mid-cycle so edge checks never race the design
  always @(negedge hclk) begin
    rdy_s = hreadyout;
    rd_s = hrdata;
    s = {thr_n, oe, irq, host_thr};
  end

  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic hang;
    err_total++;
    $display("[FAIL] %0t wait ran out", $time);
    complete_run;
  endtask
  // One single transfer; hsel stays up, htrans alone frames it
  task automatic ahb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
    int n;
    n = 0;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= w;
    do begin @(posedge hclk); n++; end while (!rdy_s && n < 40);
    htrans <= 2'b00;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (!rdy_s && n < 40);
    q = rd_s;
    if (n >= 40) hang;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge hclk);
  endtask
  task automatic wait_thr(input logic v);
    int n;
    n = 0;
    while (s[3] !== v && n < 60) begin
      @(posedge hclk);
      n++;
    end
    if (n >= 60) hang;
  endtask

  // Main sequence
  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    htrans = 2'b00;
    haddr = 32'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    sense = {10'h180, 10'h180};
    ovr_n = 1'b1;
    pwm_n = 1'b1;
    duty = 1'b0;
    err_total = 0;
    checks_done = 0;
    cyc(10);
    `CHK(s, 4'b1000)
    hresetn <= 1'b1;
    cyc(1);
    foreach (rows[i]) begin
      ahb(1'b1, rows[i].a, 32'h2);
      ahb(1'b1, rows[i].a + 8'h04, {24'h0, rows[i].td});
      ahb(1'b1, rows[i].a + 8'h08, {16'h0, rows[i].hi, rows[i].lo});
      cyc(3);
      ahb(1'b0, rows[i].a + 8'h04, 32'h0);
      `CHK(q[17:8], {rows[i].e[0], rows[i].e[1], rows[i].td})
    end
    ahb(1'b1, 8'h00, 32'h0);
    ahb(1'b1, 8'h20, 32'h0);
    // Raw path: top eight bits of each channel field
    sense <= {10'h104, 10'h2ff};
    cyc(3);
    ahb(1'b0, 8'h04, 32'h0);
    `CHK(q[15:8], 8'hbf)
    ahb(1'b0, 8'h24, 32'h0);
    `CHK(q[15:8], 8'h41)
    sense <= {10'h180, 10'h180};
    ahb(1'b1, SVTM_OFF_INT_STATUS, 32'h1ff);
    wait_thr(1'b1);
    // Override wins; pin driven only for the two-way function
    ahb(1'b1, SVTM_OFF_PIN_CFG, 32'h2);
    ovr_n <= 1'b0;
    cyc(3);
    `CHK(s, 4'b0101)
    ahb(1'b0, SVTM_OFF_PIN_CFG, 32'h0);
    `CHK(q[3:0], 4'b0010)
    ahb(1'b1, SVTM_OFF_PIN_CFG, 32'h1);
    cyc(3);
    `CHK(s, 4'b0000)
    ahb(1'b0, SVTM_OFF_PIN_CFG, 32'h0);
    `CHK(q[3:0], 4'b0101)
    ahb(1'b1, SVTM_OFF_PIN_CFG, 32'h2);
    ovr_n <= 1'b1;
    duty <= 1'b1;
    cyc(3);
    `CHK(s, 4'b0101)
    duty <= 1'b0;
    // Forced throttle raises an enabled, sticky interrupt
    ahb(1'b1, SVTM_OFF_INT_ENABLE, 32'h1);
    pwm_n <= 1'b0;
    cyc(3);
    `CHK(s, 4'b0111)
    pwm_n <= 1'b1;
    cyc(3);
    `CHK(s, 4'b1010)
    ahb(1'b1, SVTM_OFF_INT_STATUS, 32'h1);
    cyc(3);
    `CHK(s[1], 1'b0)
    ahb(1'b1, SVTM_OFF_INT_ENABLE, 32'h0);
    pwm_n <= 1'b0;
    cyc(3);
    pwm_n <= 1'b1;
    `CHK(s[1], 1'b0)
    ahb(1'b1, SVTM_OFF_INT_STATUS, 32'h1ff);
    ahb(1'b1, SVTM_OFF_INT_ENABLE, 32'h1ff);
    // Instance one high comparator through a five-cycle timer
    ahb(1'b1, 8'h34, 32'h5);
    ahb(1'b1, 8'h24, 32'hff);
    ahb(1'b1, 8'h20, 32'h2);
    cyc(3);
    `CHK(s[3], 1'b1)
    wait_thr(1'b0);
    `CHK(s[1], 1'b1)
    ahb(1'b0, SVTM_OFF_INT_STATUS, 32'h0);
    `CHK(q[8:0], 9'h040)
    ahb(1'b1, 8'h24, 32'h1);
    wait_thr(1'b1);
    ahb(1'b0, SVTM_OFF_INT_STATUS, 32'h0);
    `CHK(q[8:0], 9'h140)
    ahb(1'b1, 8'h20, 32'h3);
    ahb(1'b1, 8'h24, 32'hff);
    cyc(12);
    `CHK(s[3], 1'b1)
    // Filters: one slow step from a cleared average, then the cascade
    ahb(1'b1, 8'h0c, 32'hff);
    ahb(1'b1, 8'h04, 32'h80);
    ahb(1'b1, 8'h00, 32'h1);
    ahb(1'b1, 8'h00, 32'h16);
    cyc(300);
    ahb(1'b0, 8'h04, 32'h0);
    `CHK(q[15:8], 8'h20)
    ahb(1'b1, 8'h00, 32'h1);
    ahb(1'b1, 8'h00, 32'h6);
    cyc(300);
    ahb(1'b0, 8'h04, 32'h0);
    `CHK(q[15:8], 8'h02)
    ahb(1'b1, 8'h0c, 32'h0);
    ahb(1'b1, 8'h00, 32'h3a);
    cyc(150);
    ahb(1'b0, 8'h04, 32'h0);
    `CHK(q[15:8], 8'h80)
    // Reset in mid-run, then defaults and an unmapped read
    hresetn <= 1'b0;
    cyc(2);
    `CHK(s, 4'b1000)
    hresetn <= 1'b1;
    cyc(1);
    ahb(1'b0, 8'h08, 32'h0);
    `CHK(q, 32'h0000ff00)
    ahb(1'b0, 8'hfc, 32'h0);
    `CHK(q, 32'h0)
    `CHK(hresp, 1'b0)
    complete_run;
  end
endmodule
`default_nettype wire
